// File: common/masp_pkg.sv
/*
 * Shared constants and carriers for the measurement abort and scale
 * post-processing controller. Assumes a 32-bit Avalon-MM register bus
 * with byte addresses and one aligned word per register.
 */
package masp_pkg;
   // Register byte offsets
   localparam logic [5:0] REG_CTRL      = 6'h00;
   localparam logic [5:0] REG_CMD       = 6'h04;
   localparam logic [5:0] REG_STATUS    = 6'h08;
   localparam logic [5:0] REG_SCALE     = 6'h0c;
   localparam logic [5:0] REG_OFFSET    = 6'h10;
   localparam logic [5:0] REG_SENSED    = 6'h14;
   localparam logic [5:0] REG_RESULT    = 6'h18;
   localparam logic [5:0] REG_ERROR     = 6'h1c;
   localparam logic [5:0] REG_RESP_VAL  = 6'h20;
   localparam logic [5:0] REG_RESP_INFO = 6'h24;

   // Control register fields
   localparam int CTRL_INIT_CONT  = 0;
   localparam int CTRL_MATH_EN    = 1;
   localparam int CTRL_LIM_EN     = 2;
   localparam int CTRL_LFIL_EN    = 3;
   localparam int CTRL_AVER_EN    = 4;
   localparam int CTRL_AUTO_RECAL = 5;
   localparam int CTRL_CNT_AUTO   = 6;
   localparam int CTRL_AUTO_ARM   = 7;
   localparam int CTRL_FUNC_LO    = 8;
   localparam int CTRL_RES_LO     = 12;
   localparam logic [31:0] CTRL_WR_MASK = 32'h0000_f7ff;
   localparam logic [31:0] CTRL_RESET   = 32'h0000_0020;

   // Command register bits (write-only events)
   localparam int CMD_ABORT     = 0;
   localparam int CMD_INIT      = 1;
   localparam int CMD_RECALC    = 2;
   localparam int CMD_RECALC_Q  = 3;
   localparam int CMD_DATA_Q    = 4;
   localparam int CMD_DEF_Q     = 5;
   localparam int CMD_DEF_LAST  = 6;
   localparam int CMD_FEED_Q    = 7;
   localparam int CMD_AUTO_Q    = 8;
   localparam int CMD_CMD_RESET = 9;

   // Status register bits
   localparam int ST_PENDING   = 0;
   localparam int ST_MEASURING = 1;
   localparam int ST_VALID     = 2;
   localparam int ST_RESP_RDY  = 3;
   localparam int ST_ERR       = 4;

   localparam logic [31:0] SCALE_RESET  = 32'h0001_0000;
   localparam int          SCALE_FRAC   = 16;
   localparam logic [31:0] NAN_FLOAT    = 32'h7e95_1bea;
   localparam logic [15:0] ERR_NO_DATA  = 16'hff1a;
   localparam logic [15:0] ERR_SETTINGS = 16'hff23;
   localparam logic [15:0] ERR_QUERY    = 16'hfe48;
   localparam logic [7:0]  ASCII_ZERO   = 8'h30;
   localparam logic [3:0]  DIG_MIN      = 4'h1;
   localparam logic [3:0]  DIG_MAX      = 4'hf;

   typedef enum logic [2:0] {
      FN_FREQ  = 3'h0,
      FN_TOT   = 3'h1,
      FN_VPEAK = 3'h2,
      FN_VMIN  = 3'h3,
      FN_VMAX  = 3'h4,
      FN_OTHER = 3'h5
   } masp_func_type;

   typedef enum logic [2:0] {
      RK_NONE = 3'h0,
      RK_NR3  = 3'h1,
      RK_NAN  = 3'h2,
      RK_BYTE = 3'h3,
      RK_SENS = 3'h4,
      RK_EXPR = 3'h5
   } masp_resp_type;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [5:0]  address;
      logic [31:0] writedata;
   } masp_avs_req_type;

   typedef struct packed {
      logic start;
      logic stop;
      logic lim_active;
      logic lfil_active;
      logic aver_active;
      logic lim_recalc;
      logic lim_cnt_clear;
   } masp_meas_ctl_type;
endpackage

// File: core/masp_ctrl.sv
/*
 * Command controller: abort handling, pending and measuring flags,
 * scale/offset post-processing with manual or automatic recalculation,
 * query holdoff and error reporting, on an Avalon-MM slave.
 * Assumes the acquisition engine and stage logic run on i_sys_clk;
 * only the device clear input comes from outside and is synchronised.
 */
`timescale 1ns/10ps
// Summary of operation
// - Abort while idle with continuous run off changes nothing.
// - Abort of a single pending measurement stops it and clears pending.
// - Abort in continuous run stops, clears pending, restarts, sets pending again.
// - Abort of a pending statistics block ends the block, clears pending.
// - Abort of a running measurement clears the measuring status bit unless continuous run sets it again.
// - Aborted result becomes invalid, except auto-armed totalize, which takes the count at the stop as a valid result.
// - Abort completes on the bus only once the measurement has stopped.
// - Totalize and voltage peak functions bypass every post-processing stage.
// - Scale and offset apply only while math is enabled.
// - Limit, limit filter and averaging act only with their own enable.
// - Result query with no valid result returns not-a-number and error -230.
// - Result query under totalize or voltage peaks gives not-a-number, -221.
// - ASCII results use exponent form with 1 to 15 significant digits.
// - Result query with math on while measuring stalls until done or clear.
// - Recalculate reruns scale and limit on stored data, counts untouched.
// - Recalculate query recalculates, then returns the new result.
// - Auto recalculation off: new results only on acquisition or recalculate.
// - Auto recalculation on at power-up, off after command reset; query 0/1.
// - Input source is the sensing function only; query returns its name.
// - A result stays valid until replaced or relevant state changes.
// - Expression query returns fixed formula; not last in message gives -440.
// - Initiation sets pending; abort forces it false unless continuous run is on.
// - Changing math enable clears limit pass and fail counts.
module masp_ctrl
   import masp_pkg::*;
(
   // Clock and reset
   input  wire logic              i_sys_clk,
   input  wire logic              i_rst,
   // Avalon-MM slave
   input  wire logic              i_avs_read,
   input  wire logic              i_avs_write,
   input  wire logic [5:0]        i_avs_address,
   input  wire logic [31:0]       i_avs_writedata,
   output logic                   o_avs_waitrequest,
   output logic [31:0]            o_avs_readdata,
   // Acquisition engine
   input  wire logic              i_meas_done,
   input  wire logic              i_meas_stopped,
   input  wire logic [31:0]       i_meas_data,
   input  wire logic              i_dev_clear,
   output masp_meas_ctl_type      o_meas_ctl
);
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_ABORT = 2'b01,
      ST_HOLD  = 2'b10
   } masp_state_type;

   masp_avs_req_type req;
   masp_state_type   state, next_state;
   logic [31:0] ctrl, next_ctrl, scale, next_scale, offset, next_offset;
   logic [31:0] sensed, next_sensed, result, next_result;
   logic [31:0] resp_val, next_resp_val;
   logic [2:0]  resp_kind, next_resp_kind;
   logic [15:0] err_code, next_err_code;
   logic        pending, next_pending, measuring, next_measuring;
   logic        valid, next_valid, resp_rdy, next_resp_rdy, err_flag, next_err_flag;
   logic        clr_meta, clr_sync;
   logic        ready, fire_wr, fire_rd, stall;
   masp_meas_ctl_type next_ctl;

   function automatic logic bypass_fn(input logic [31:0] c);
      logic [2:0] f;
      f = c[CTRL_FUNC_LO +: 3];
      bypass_fn = (f == FN_TOT) || (f == FN_VPEAK) || (f == FN_VMIN) || (f == FN_VMAX);
   endfunction

   function automatic logic [31:0] calc_fn(input logic [31:0] c, input logic [31:0] d,
                                            input logic [31:0] s, input logic [31:0] o);
      logic signed [63:0] p;
      p = $signed(d) * $signed(s);
      if (c[CTRL_MATH_EN] && !bypass_fn(c))
         calc_fn = 32'(p >>> SCALE_FRAC) + o;
      else
         calc_fn = d;
   endfunction

   function automatic logic [3:0] digits_fn(input logic [31:0] c);
      logic [3:0] r;
      r = c[CTRL_RES_LO +: 4];
      digits_fn = (r < DIG_MIN) ? DIG_MIN : ((r > DIG_MAX) ? DIG_MAX : r);
   endfunction

   assign req = '{read: i_avs_read, write: i_avs_write,
                  address: i_avs_address, writedata: i_avs_writedata};

   // Device clear comes from the bus interface, another timing domain
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         clr_meta <= 1'b0;
         clr_sync <= 1'b0;
      end else begin
         clr_meta <= i_dev_clear;
         clr_sync <= clr_meta;
      end
   end

   // Commands that must wait on the acquisition engine
   always_comb begin
      stall = 1'b0;
      if (req.write && req.address == REG_CMD) begin
         if (req.writedata[CMD_ABORT] && pending)
            stall = 1'b1;
         // A completing measurement answers at once, else hold would wait forever
         if ((req.writedata[CMD_DATA_Q] || req.writedata[CMD_RECALC_Q])
             && ctrl[CTRL_MATH_EN] && pending && !i_meas_done)
            stall = 1'b1;
      end
   end

   always_comb begin
      case (state)
         ST_IDLE:  ready = !stall;
         ST_ABORT: ready = i_meas_stopped;
         ST_HOLD:  ready = i_meas_done || clr_sync;
         default:  ready = 1'b1;
      endcase
   end

   assign o_avs_waitrequest = (req.read || req.write) && !ready;
   assign fire_wr = req.write && ready;
   assign fire_rd = req.read && ready;

   always_comb begin
      case (req.address)
         REG_CTRL:      o_avs_readdata = ctrl;
         REG_STATUS:    o_avs_readdata = {27'h0, err_flag, resp_rdy, valid, measuring, pending};
         REG_SCALE:     o_avs_readdata = scale;
         REG_OFFSET:    o_avs_readdata = offset;
         REG_SENSED:    o_avs_readdata = sensed;
         REG_RESULT:    o_avs_readdata = result;
         REG_ERROR:     o_avs_readdata = {16'h0, err_code};
         REG_RESP_VAL:  o_avs_readdata = resp_val;
         REG_RESP_INFO: o_avs_readdata = {24'h0, 1'b0, digits_fn(ctrl), resp_kind};
         default:       o_avs_readdata = 32'h0;
      endcase
   end

   always_comb begin
      logic [31:0] cmd, wctrl;
      logic        recalc, query, chg;
      cmd = (fire_wr && req.address == REG_CMD) ? req.writedata : 32'h0;
      wctrl = (ctrl & ~CTRL_WR_MASK) | (req.writedata & CTRL_WR_MASK);
      recalc = 1'b0;
      query = 1'b0;
      chg = 1'b0;
      next_state = state;
      next_ctrl = ctrl;
      next_scale = scale;
      next_offset = offset;
      next_sensed = sensed;
      next_result = result;
      next_valid = valid;
      next_pending = pending;
      next_measuring = measuring;
      next_resp_val = resp_val;
      next_resp_kind = resp_kind;
      next_resp_rdy = resp_rdy;
      next_err_code = err_code;
      next_err_flag = err_flag;
      next_ctl = '0;

      // Software clears first so a hardware set in the same cycle wins
      if (fire_wr && req.address == REG_STATUS) begin
         if (req.writedata[ST_RESP_RDY])
            next_resp_rdy = 1'b0;
         if (req.writedata[ST_ERR])
            next_err_flag = 1'b0;
      end

      // Post-processing settings
      if (fire_wr && req.address == REG_CTRL) begin
         next_ctrl = wctrl;
         if (wctrl[CTRL_MATH_EN] != ctrl[CTRL_MATH_EN])
            next_ctl.lim_cnt_clear = 1'b1;
         if (wctrl[CTRL_FUNC_LO +: 3] != ctrl[CTRL_FUNC_LO +: 3])
            next_valid = 1'b0;
         chg = 1'b1;
      end
      if (fire_wr && req.address == REG_SCALE) begin
         next_scale = req.writedata;
         chg = 1'b1;
      end
      if (fire_wr && req.address == REG_OFFSET) begin
         next_offset = req.writedata;
         chg = 1'b1;
      end
      if (chg && ctrl[CTRL_AUTO_RECAL])
         recalc = 1'b1;
      if (cmd[CMD_CMD_RESET])
         next_ctrl[CTRL_AUTO_RECAL] = 1'b0;

      // New acquisition
      if (i_meas_done && pending && state != ST_ABORT) begin
         next_sensed = i_meas_data;
         next_result = calc_fn(next_ctrl, i_meas_data, next_scale, next_offset);
         next_valid = 1'b1;
         if (ctrl[CTRL_INIT_CONT]) begin
            next_ctl.start = 1'b1;
         end else begin
            next_pending = 1'b0;
            next_measuring = 1'b0;
         end
      end

      // Initiation
      if (cmd[CMD_INIT] && !pending) begin
         next_pending = 1'b1;
         next_measuring = 1'b1;
         next_ctl.start = 1'b1;
      end
      if (fire_wr && req.address == REG_CTRL && wctrl[CTRL_INIT_CONT] && !pending) begin
         next_pending = 1'b1;
         next_measuring = 1'b1;
         next_ctl.start = 1'b1;
      end

      case (state)
         ST_IDLE: begin
            if (cmd[CMD_ABORT] && !pending) begin
               // Nothing in progress: command is a no-op
            end
            // Abort acts on the stalled request, before it is accepted
            if (req.write && req.address == REG_CMD && req.writedata[CMD_ABORT] && pending) begin
               next_ctl.stop = 1'b1;
               next_state = ST_ABORT;
            end else if (stall) begin
               next_state = ST_HOLD;
            end
            if (cmd[CMD_RECALC] || cmd[CMD_RECALC_Q])
               recalc = 1'b1;
            if (cmd[CMD_DATA_Q] || cmd[CMD_RECALC_Q])
               query = 1'b1;
         end
         ST_ABORT: begin
            if (i_meas_stopped) begin
               next_state = ST_IDLE;
               next_pending = 1'b0;
               next_measuring = 1'b0;
               if (!(ctrl[CTRL_FUNC_LO +: 3] == FN_TOT && ctrl[CTRL_AUTO_ARM]))
                  next_valid = 1'b0;
               else begin
                  next_sensed = i_meas_data;
                  next_result = calc_fn(ctrl, i_meas_data, scale, offset);
                  next_valid = 1'b1;
               end
               if (ctrl[CTRL_INIT_CONT]) begin
                  next_pending = 1'b1;
                  next_measuring = 1'b1;
                  next_ctl.start = 1'b1;
               end
            end
         end
         ST_HOLD: begin
            if (clr_sync) begin
               next_state = ST_IDLE;
            end else if (i_meas_done) begin
               next_state = ST_IDLE;
               if (req.writedata[CMD_RECALC_Q])
                  recalc = 1'b1;
               query = 1'b1;
            end
         end
         default: next_state = ST_IDLE;
      endcase

      if (recalc) begin
         next_result = calc_fn(next_ctrl, next_sensed, next_scale, next_offset);
         next_ctl.lim_recalc = next_ctrl[CTRL_LIM_EN] && !bypass_fn(next_ctrl);
      end

      if (query) begin
         next_resp_rdy = 1'b1;
         if (bypass_fn(next_ctrl)) begin
            next_resp_kind = RK_NAN;
            next_resp_val = NAN_FLOAT;
            next_err_code = ERR_SETTINGS;
            next_err_flag = 1'b1;
         end else if (!next_valid) begin
            next_resp_kind = RK_NAN;
            next_resp_val = NAN_FLOAT;
            next_err_code = ERR_NO_DATA;
            next_err_flag = 1'b1;
         end else begin
            next_resp_kind = RK_NR3;
            next_resp_val = next_result;
         end
      end
      if (cmd[CMD_AUTO_Q]) begin
         next_resp_rdy = 1'b1;
         next_resp_kind = RK_BYTE;
         next_resp_val = {24'h0, ASCII_ZERO | {7'h0, next_ctrl[CTRL_AUTO_RECAL]}};
      end
      if (cmd[CMD_FEED_Q]) begin
         next_resp_rdy = 1'b1;
         next_resp_kind = RK_SENS;
         next_resp_val = 32'h0;
      end
      if (cmd[CMD_DEF_Q]) begin
         next_resp_rdy = 1'b1;
         next_resp_kind = RK_EXPR;
         next_resp_val = 32'h0;
         if (!cmd[CMD_DEF_LAST]) begin
            next_err_code = ERR_QUERY;
            next_err_flag = 1'b1;
         end
      end

      next_ctl.lim_active  = next_ctrl[CTRL_LIM_EN] && !bypass_fn(next_ctrl);
      next_ctl.lfil_active = next_ctrl[CTRL_LFIL_EN] && !bypass_fn(next_ctrl);
      next_ctl.aver_active = next_ctrl[CTRL_AVER_EN] && !bypass_fn(next_ctrl);
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         state      <= ST_IDLE;
         ctrl       <= CTRL_RESET;
         scale      <= SCALE_RESET;
         offset     <= 32'h0;
         sensed     <= 32'h0;
         result     <= 32'h0;
         valid      <= 1'b0;
         pending    <= 1'b0;
         measuring  <= 1'b0;
         resp_val   <= 32'h0;
         resp_kind  <= RK_NONE;
         resp_rdy   <= 1'b0;
         err_code   <= 16'h0;
         err_flag   <= 1'b0;
         o_meas_ctl <= '0;
      end else begin
         state      <= next_state;
         ctrl       <= next_ctrl;
         scale      <= next_scale;
         offset     <= next_offset;
         sensed     <= next_sensed;
         result     <= next_result;
         valid      <= next_valid;
         pending    <= next_pending;
         measuring  <= next_measuring;
         resp_val   <= next_resp_val;
         resp_kind  <= next_resp_kind;
         resp_rdy   <= next_resp_rdy;
         err_code   <= next_err_code;
         err_flag   <= next_err_flag;
         o_meas_ctl <= next_ctl;
      end
   end

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);

   logic abort_fire;
   assign abort_fire = req.write && req.address == REG_CMD && req.writedata[CMD_ABORT];

   idle_abort_a: assert property (abort_fire && state == ST_IDLE && !pending
      && !ctrl[CTRL_INIT_CONT] |=> !pending && !o_meas_ctl.stop)
      else $error("idle abort changed state");
   abort_stop_a: assert property (abort_fire && state == ST_IDLE && pending
      |=> o_meas_ctl.stop && state == ST_ABORT)
      else $error("abort did not stop measurement");
   abort_wait_a: assert property (state == ST_ABORT && !i_meas_stopped
      && (req.read || req.write) |-> o_avs_waitrequest)
      else $error("abort completed before stop");
   abort_clear_a: assert property (state == ST_ABORT && i_meas_stopped
      && !ctrl[CTRL_INIT_CONT] |=> !pending && !measuring)
      else $error("abort left pending or measuring");
   cont_restart_a: assert property (state == ST_ABORT && i_meas_stopped
      && ctrl[CTRL_INIT_CONT] |=> pending && o_meas_ctl.start)
      else $error("continuous abort did not restart");
   abort_inval_a: assert property (state == ST_ABORT && i_meas_stopped
      && ctrl[CTRL_FUNC_LO +: 3] != FN_TOT |=> !valid)
      else $error("aborted result still valid");
   measuring_clear_a: assert property (state == ST_ABORT ##1 state == ST_IDLE
      && !ctrl[CTRL_INIT_CONT] |-> !measuring)
      else $error("measuring bit left set");
   bypass_stage_a: assert property (bypass_fn(ctrl) |-> !o_meas_ctl.lim_active
      && !o_meas_ctl.aver_active && !o_meas_ctl.lfil_active)
      else $error("stage active under bypass function");
   hold_query_a: assert property (state == ST_HOLD && !i_meas_done && !clr_sync
      |-> o_avs_waitrequest)
      else $error("held query answered early");
   nan_err_a: assert property (state == ST_HOLD && i_meas_done && !clr_sync
      && bypass_fn(ctrl) |=> resp_kind == RK_NAN && err_code == ERR_SETTINGS)
      else $error("bypass query not reported");
   math_clear_a: assert property (fire_wr && req.address == REG_CTRL
      && req.writedata[CTRL_MATH_EN] != ctrl[CTRL_MATH_EN] |=> o_meas_ctl.lim_cnt_clear)
      else $error("limit counts not cleared");
   auto_reset_a: assert property (fire_wr && req.address == REG_CMD
      && req.writedata[CMD_CMD_RESET] |=> !ctrl[CTRL_AUTO_RECAL])
      else $error("command reset left auto recalculation on");

   abort_single_c: cover property (state == ST_ABORT ##1 state == ST_IDLE && !pending);
   abort_cont_c:   cover property (state == ST_ABORT ##1 state == ST_IDLE && pending);
   hold_done_c:    cover property (state == ST_HOLD ##1 resp_rdy && resp_kind == RK_NR3);
   hold_clear_c:   cover property (state == ST_HOLD && clr_sync);
endmodule

// File: sim/masp_acq_model.sv
/*
 * Stand-in for the acquisition engine behind the controller.
 * Assumes the controller's start and stop are one-cycle pulses on i_sys_clk.
 */
`timescale 1ns/10ps
module masp_acq_model
   import masp_pkg::*;
#(
   parameter int DONE_DLY = 40
)(
   // Clock and reset
   input  wire logic         i_sys_clk,
   input  wire logic         i_rst,
   // Controller side
   input  masp_meas_ctl_type i_meas_ctl,
   output logic              o_meas_done,
   output logic              o_meas_stopped,
   output logic [31:0]       o_meas_data
);
   int          run_cnt;
   int          stop_cnt;
   logic [31:0] churn;
   assign o_meas_done    = (run_cnt == 1);
   assign o_meas_stopped = (stop_cnt == 1);
   // Data is only meaningful with done or stopped; it churns otherwise
   assign o_meas_data    = (o_meas_done || o_meas_stopped) ? 32'h0000_0064 : churn;
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         run_cnt  <= 0;
         stop_cnt <= 0;
         churn    <= '0;
      end else begin
         churn <= churn + 32'h9e37_79b9;
         if (i_meas_ctl.stop) run_cnt <= 0;
         else if (i_meas_ctl.start) run_cnt <= DONE_DLY;
         else if (run_cnt > 0) run_cnt <= run_cnt - 1;
         // Stop takes a few cycles, so an abort must really stall
         if (i_meas_ctl.stop) stop_cnt <= 3;
         else if (stop_cnt > 0) stop_cnt <= stop_cnt - 1;
      end
   end
endmodule

// File: sim/testbench.sv
/*
 * Self-checking bench for masp_ctrl, one task per scenario.
 * Assumes masp_acq_model answers on the acquisition side.
 */
`timescale 1ns/10ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin bad_count++; \
   $display("wrong value %s exp %h got %h", n, e, s); end end
module testbench;
   import masp_pkg::*;
   logic              i_sys_clk = 1'b0;
   logic              i_rst     = 1'b1;
   masp_avs_req_type  req       = '0;
   logic              wait_req;
   logic [31:0]       rdata;
   logic              done;
   logic              stopped;
   logic [31:0]       mdata;
   masp_meas_ctl_type ctl;
   logic [31:0]       rv;
   logic              dev_clr   = 1'b0;
   int                bad_count = 0;
   int                cmp_count = 0;
   always #10 i_sys_clk = ~i_sys_clk;
   masp_ctrl dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_avs_read(req.read),
      .i_avs_write(req.write), .i_avs_address(req.address),
      .i_avs_writedata(req.writedata), .o_avs_waitrequest(wait_req),
      .o_avs_readdata(rdata), .i_meas_done(done), .i_meas_stopped(stopped),
      .i_meas_data(mdata), .i_dev_clear(dev_clr), .o_meas_ctl(ctl));
   masp_acq_model #(.DONE_DLY(40)) acq (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
      .i_meas_ctl(ctl), .o_meas_done(done), .o_meas_stopped(stopped),
      .o_meas_data(mdata));
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      int n;
      @(posedge i_sys_clk);
      req <= '{read: !w, write: w, address: a, writedata: d};
      n = 0;
      do begin
         @(posedge i_sys_clk);
         n++;
      end while (wait_req !== 1'b0 && n < 3000);
      rv = rdata;
      req <= '0;
      if (n >= 3000) begin
         bad_count++;
         final_report();
      end
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e,
                     input string n);
      bus(1'b0, a, '0);
      `CHK(n, e, rv & m)
   endtask
   task automatic wait_valid();
      int n;
      n = 0;
      do begin
         bus(1'b0, REG_STATUS, '0);
         n++;
      end while (rv[ST_VALID] !== 1'b1 && n < 200);
      if (n >= 200) begin
         bad_count++;
         final_report();
      end
   endtask
   task automatic t_power();
      rd(REG_CTRL, 32'hffff_ffff, CTRL_RESET, "ctrl");
      bus(1'b1, REG_CMD, 32'h1 << CMD_AUTO_Q);
      rd(REG_RESP_VAL, 32'hff, 32'h31, "auto on");
      bus(1'b1, REG_CMD, 32'h1 << CMD_CMD_RESET);
      bus(1'b1, REG_CMD, 32'h1 << CMD_AUTO_Q);
      rd(REG_RESP_VAL, 32'hff, 32'h30, "auto off");
      bus(1'b1, REG_CTRL, 32'h20);
   endtask
   task automatic t_abort();
      bus(1'b1, REG_CMD, 32'h1);
      rd(REG_STATUS, 32'h7, 32'h0, "idle abort");
      bus(1'b1, REG_CMD, 32'h2);
      rd(REG_STATUS, 32'h1, 32'h1, "pending");
      // Write stalls until the engine confirms the stop
      bus(1'b1, REG_CMD, 32'h1);
      rd(REG_STATUS, 32'h7, 32'h0, "aborted");
   endtask
   task automatic t_math();
      bus(1'b1, REG_CTRL, 32'h22);
      bus(1'b1, REG_SCALE, 32'h0002_0000);
      bus(1'b1, REG_OFFSET, 32'h5);
      bus(1'b1, REG_CMD, 32'h2);
      wait_valid();
      rd(REG_RESULT, 32'hffff_ffff, 32'hcd, "scaled");
      bus(1'b1, REG_CTRL, 32'h20);
      rd(REG_RESULT, 32'hffff_ffff, 32'h64, "unscaled");
   endtask
   task automatic t_hold();
      bus(1'b1, REG_CTRL, 32'h22);
      bus(1'b1, REG_CMD, 32'h2);
      bus(1'b1, REG_CMD, 32'h1 << CMD_RECALC_Q);
      rd(REG_STATUS, 32'h5, 32'h4, "held done");
      rd(REG_RESP_VAL, 32'hffff_ffff, 32'hcd, "recalc resp");
   endtask
   task automatic t_errors();
      bus(1'b1, REG_CTRL, 32'h122);
      bus(1'b1, REG_CMD, 32'h1 << CMD_DATA_Q);
      rd(REG_ERROR, 32'hffff, {16'h0, ERR_SETTINGS}, "bypass err");
      rd(REG_RESP_VAL, 32'hffff_ffff, NAN_FLOAT, "bypass nan");
      bus(1'b1, REG_CTRL, 32'h20);
      bus(1'b1, REG_CMD, 32'h1 << CMD_DATA_Q);
      rd(REG_ERROR, 32'hffff, {16'h0, ERR_NO_DATA}, "no data err");
      rd(REG_RESP_VAL, 32'hffff_ffff, NAN_FLOAT, "no data nan");
   endtask
   task automatic t_cont();
      bus(1'b1, REG_CTRL, 32'h21);
      bus(1'b1, REG_CMD, 32'h1);
      rd(REG_STATUS, 32'h1, 32'h1, "restarted");
      bus(1'b1, REG_CTRL, 32'h20);
      bus(1'b1, REG_CMD, 32'h1);
      rd(REG_STATUS, 32'h3, 32'h0, "stopped");
   endtask
   task automatic t_query();
      bus(1'b1, REG_STATUS, 32'h18);
      bus(1'b1, REG_CMD, (32'h1 << CMD_DEF_Q) | (32'h1 << CMD_DEF_LAST));
      rd(REG_STATUS, 32'h18, 32'h8, "expr last");
      bus(1'b1, REG_CMD, 32'h1 << CMD_DEF_Q);
      rd(REG_ERROR, 32'hffff, {16'h0, ERR_QUERY}, "expr err");
      bus(1'b1, REG_CMD, 32'h1 << CMD_FEED_Q);
      rd(REG_RESP_INFO, 32'h7f, 32'h0c, "feed info");
      bus(1'b1, REG_CTRL, 32'h24);
      rd(REG_STATUS, 32'h1, 32'h0, "lim idle");
      `CHK("lim active", 1'b1, ctl.lim_active)
   endtask
   task automatic t_clear();
      bus(1'b1, REG_CMD, 32'h1 << CMD_CMD_RESET);
      bus(1'b1, REG_CTRL, 32'h02);
      rd(REG_RESULT, 32'hffff_ffff, 32'h64, "no auto");
      bus(1'b1, REG_CMD, 32'h1 << CMD_RECALC);
      rd(REG_RESULT, 32'hffff_ffff, 32'hcd, "recalc");
      bus(1'b1, REG_STATUS, 32'h8);
      bus(1'b1, REG_CMD, 32'h2);
      // Device clear must free the held query long before the measurement ends
      fork
         bus(1'b1, REG_CMD, 32'h1 << CMD_DATA_Q);
         begin
            repeat (5) @(posedge i_sys_clk);
            dev_clr <= 1'b1;
            repeat (4) @(posedge i_sys_clk);
            dev_clr <= 1'b0;
         end
      join
      rd(REG_STATUS, 32'h9, 32'h1, "cleared hold");
   endtask
   initial begin
      repeat (20) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      t_power();
      t_abort();
      t_math();
      t_hold();
      t_errors();
      t_cont();
      t_query();
      t_clear();
      final_report();
   end
endmodule
